// File: shared/motor_timer_defines.svh
`ifndef MOTOR_TIMER_DEFINES_SVH
`define MOTOR_TIMER_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_CTRL      8'h00
`define OFS_PRESCALE  8'h04
`define OFS_RELOAD    8'h08
`define OFS_REPEAT    8'h0C
`define OFS_CHMODE    8'h10
`define OFS_DEADTIME  8'h14
`define OFS_BREAKCFG  8'h18
`define OFS_STATUS    8'h1C
`define OFS_MASK      8'h20
`define OFS_COUNT     8'h24
`define OFS_CCV0      8'h30

// ****************************************
// Control register field positions
// ****************************************
`define CTRL_ENABLE   0
`define CTRL_DIR_LO   1
`define CTRL_DIR_HI   2
`define CTRL_ONEPULSE 3

// ****************************************
// Status bit positions
// ****************************************
`define ST_UPDATE     0
`define ST_CH0        1
`define ST_BREAK      5
`define ST_HALL       6
`define ST_WIDTH      7

// ****************************************
// Reset values
// ****************************************
`define RST_RELOAD    16'hFFFF
`define RST_PRESCALE  16'h0000
`define RST_DEADTIME  8'h00

`endif

// File: shared/motor_timer_pkg.sv
package motor_timer_pkg;

    // Counting direction
    typedef enum logic [1:0] {
        COUNT_UP     = 2'h0,
        COUNT_DOWN   = 2'h1,
        COUNT_CENTER = 2'h2
    } count_mode_e;

    // Per-channel function
    typedef enum logic [2:0] {
        CH_OFF     = 3'h0,
        CH_CAPTURE = 3'h1,
        CH_TOGGLE  = 3'h2,
        CH_PWM     = 3'h3,
        CH_PWM_INV = 3'h4
    } chan_mode_e;

    // Dead time unit states
    typedef enum logic [2:0] {
        DT_LOW  = 3'b001,
        DT_WAIT = 3'b010,
        DT_HIGH = 3'b100
    } dead_state_e;

    // Register bus request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_s;

    // One complementary output pair
    typedef struct packed {
        logic main;
        logic comp;
    } pin_pair_s;

endpackage

// File: core/dead_time_pair.sv
`include "motor_timer_defines.svh"

// Complementary output with dead time between the two phases
module dead_time_pair
    import motor_timer_pkg::*;
(
    // Clock and reset
    input  wire logic      clock_in,
    input  wire logic      srst_in,
    // Control
    input  wire logic      ref_in,
    input  wire logic [7:0] dead_in,
    input  wire logic      force_in,
    input  wire pin_pair_s safe_in,
    // Output pair
    output pin_pair_s      pair_out
);

    dead_state_e st_q, st_d;
    logic [7:0]  cnt_q, cnt_d;
    logic        tgt_q, tgt_d;
    pin_pair_s   pair_d;

    // Next state: each reference edge passes through a dead gap when dead_in is nonzero
    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        tgt_d = tgt_q;
        unique case (st_q)
            DT_LOW, DT_HIGH: begin
                if (ref_in != (st_q == DT_HIGH)) begin
                    tgt_d = ref_in;
                    cnt_d = dead_in;
                    st_d  = (dead_in == 8'h00) ? (ref_in ? DT_HIGH : DT_LOW) : DT_WAIT;
                end
            end
            DT_WAIT: begin
                if (cnt_q <= 8'h01) begin
                    st_d = tgt_q ? DT_HIGH : DT_LOW;
                end
                cnt_d = cnt_q - 8'h01;
            end
            default: st_d = DT_LOW;
        endcase
        // Both off during the gap, forced safe level on break
        pair_d.main = (st_d == DT_HIGH);
        pair_d.comp = (st_d == DT_LOW);
        if (force_in) begin
            pair_d = safe_in;
        end
    end

    // State registers
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            st_q     <= DT_LOW;
            cnt_q    <= 8'h00;
            tgt_q    <= 1'b0;
            pair_out <= '0;
        end else begin
            st_q     <= st_d;
            cnt_q    <= cnt_d;
            tgt_q    <= tgt_d;
            pair_out <= pair_d;
        end
    end

    gap_both_off_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (st_q == DT_WAIT && !$past(force_in, 1) && !force_in) |=> 1'b1 ##0
        (!(pair_out.main && pair_out.comp)))
        else $error("pair outputs both on");

endmodule

// File: core/motor_timer.sv
// Local design decisions: strobed register access and the address map.
`include "motor_timer_defines.svh"

// Function
// - The counter is 16 bits, auto-reloads and counts up, down or up then down.
// - A 16-bit prescaler divides the clock by any factor from 1 to 65536.
// - Four channels each have their own 16-bit capture/compare value.
// - A 16-bit reload register sets the period and an 8-bit repetition counter runs beside it.
// - A capture channel latches the counter on a rising input edge.
// - A compare channel toggles its output when the counter equals its value.
// - PWM is produced edge-aligned or center-aligned as configured.
// - Single-pulse mode stops the counter at the next update event.
// - Complementary pairs get a programmable dead gap between phases.
// - A break input forces the phase outputs to reset state or to a set safe state.
// - Hall sensor inputs trigger capture on channel 0 and raise a status event.
module motor_timer
    import motor_timer_pkg::*;
(
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        srst_in,
    // Register port
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic [31:0]      rdata_out,
    // Motor pins
    input  wire logic [3:0]  capture_in,
    input  wire logic [2:0]  hall_in,
    input  wire logic        break_in,
    output logic [3:0]       ch_out,
    output logic [2:0]       phase_hi_out,
    output logic [2:0]       phase_lo_out,
    output logic             irq_out
);

    // ****************************************
    // Registers and state
    // ****************************************
    bus_req_s            req;
    logic [7:0]          ctrl_q, ctrl_d;
    logic [15:0]         psc_q, psc_d;
    logic [15:0]         pcnt_q, pcnt_d;
    logic [15:0]         reload_q, reload_d;
    logic [15:0]         cnt_q, cnt_d;
    logic                down_q, down_d;
    logic [7:0]          rep_cfg_q, rep_cfg_d;
    logic [7:0]          rep_q, rep_d;
    logic [11:0]         chmode_q, chmode_d;
    logic [7:0]          dead_q, dead_d;
    logic [3:0]          brk_cfg_q, brk_cfg_d;
    logic [`ST_WIDTH-1:0] stat_q, stat_d;
    logic [`ST_WIDTH-1:0] mask_q, mask_d;
    logic [15:0]         ccv_q [4];
    logic [15:0]         ccv_d [4];
    logic [3:0]          cap_prev_q;
    logic [2:0]          hall_prev_q;
    logic [3:0]          ch_d;
    logic [31:0]         rdata_d;
    logic                irq_d;
    logic                brk_q, brk_d;
    logic                tick;
    logic                period_end;
    logic [`ST_WIDTH-1:0] events;
    count_mode_e         mode;
    logic [3:0]          cap_edge;
    logic                hall_edge;

    assign req  = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
    assign mode = count_mode_e'(ctrl_q[`CTRL_DIR_HI:`CTRL_DIR_LO]);

    // ****************************************
    // Prescaler and counter
    // ****************************************

    // Prescaler: tick once every psc+1 clocks, no long stall when psc is lowered
    always_comb begin
        tick   = ctrl_q[`CTRL_ENABLE] && (pcnt_q >= psc_q);
        pcnt_d = !ctrl_q[`CTRL_ENABLE] ? 16'h0000 :
                 (tick ? 16'h0000 : pcnt_q + 16'h0001);
    end

    // Counter with reload, direction and repetition
    always_comb begin
        cnt_d      = cnt_q;
        down_d     = down_q;
        rep_d      = rep_q;
        period_end = 1'b0;
        if (tick) begin
            unique case (mode)
                COUNT_DOWN: begin
                    if (cnt_q == 16'h0000) begin
                        cnt_d      = reload_q;
                        period_end = 1'b1;
                    end else begin
                        cnt_d = cnt_q - 16'h0001;
                    end
                end
                COUNT_CENTER: begin
                    if (!down_q && cnt_q >= reload_q) begin
                        down_d = 1'b1;
                        cnt_d  = cnt_q - 16'h0001;
                    end else if (down_q && cnt_q <= 16'h0001) begin
                        down_d     = 1'b0;
                        cnt_d      = 16'h0000;
                        period_end = 1'b1;
                    end else begin
                        cnt_d = down_q ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
                    end
                end
                default: begin
                    if (cnt_q >= reload_q) begin
                        cnt_d      = 16'h0000;
                        period_end = 1'b1;
                    end else begin
                        cnt_d = cnt_q + 16'h0001;
                    end
                end
            endcase
        end
        if (period_end) begin
            rep_d = (rep_q == 8'h00) ? rep_cfg_q : rep_q - 8'h01;
        end
    end

    // ****************************************
    // Channels, events and registers
    // ****************************************

    // Input edges from capture pins and hall sensors
    assign cap_edge  = capture_in & ~cap_prev_q;
    assign hall_edge = |(hall_in ^ hall_prev_q);

    // Channel outputs, captures, register writes and status
    always_comb begin
        ctrl_d    = ctrl_q;
        psc_d     = psc_q;
        reload_d  = reload_q;
        rep_cfg_d = rep_cfg_q;
        chmode_d  = chmode_q;
        dead_d    = dead_q;
        brk_cfg_d = brk_cfg_q;
        mask_d    = mask_q;
        ccv_d     = ccv_q;
        ch_d      = ch_out;
        events    = '0;
        brk_d     = brk_q | break_in;
        events[`ST_UPDATE] = period_end && (rep_q == 8'h00);
        events[`ST_BREAK]  = break_in;
        events[`ST_HALL]   = hall_edge;
        for (int i = 0; i < 4; i++) begin
            unique case (chan_mode_e'(chmode_q[3*i +: 3]))
                CH_CAPTURE: begin
                    if (cap_edge[i] || (i == 0 && hall_edge)) begin
                        ccv_d[i] = cnt_q;
                        events[`ST_CH0 + i] = 1'b1;
                    end
                end
                CH_TOGGLE: begin
                    if (tick && cnt_q == ccv_q[i]) begin
                        ch_d[i] = !ch_out[i];
                        events[`ST_CH0 + i] = 1'b1;
                    end
                end
                CH_PWM:     ch_d[i] = (cnt_q < ccv_q[i]);
                CH_PWM_INV: ch_d[i] = (cnt_q >= ccv_q[i]);
                default:    ch_d[i] = 1'b0;
            endcase
        end
        // Single pulse: stop at the update event
        if (ctrl_q[`CTRL_ONEPULSE] && events[`ST_UPDATE]) begin
            ctrl_d[`CTRL_ENABLE] = 1'b0;
        end
        if (req.wr) begin
            unique case (req.addr)
                `OFS_CTRL:     ctrl_d    = req.wdata[7:0];
                `OFS_PRESCALE: psc_d     = req.wdata[15:0];
                `OFS_RELOAD:   reload_d  = req.wdata[15:0];
                `OFS_REPEAT:   rep_cfg_d = req.wdata[7:0];
                `OFS_CHMODE:   chmode_d  = req.wdata[11:0];
                `OFS_DEADTIME: dead_d    = req.wdata[7:0];
                `OFS_BREAKCFG: brk_cfg_d = req.wdata[3:0];
                `OFS_MASK:     mask_d    = req.wdata[`ST_WIDTH-1:0];
                `OFS_STATUS:   brk_d     = brk_q && !req.wdata[`ST_BREAK] || break_in;
                default: begin
                    for (int i = 0; i < 4; i++) begin
                        if (req.addr == `OFS_CCV0 + 8'(4*i)) begin
                            ccv_d[i] = req.wdata[15:0];
                        end
                    end
                end
            endcase
        end
        // Sticky status, the set wins over a write-one clear
        stat_d = (stat_q & ~((req.wr && req.addr == `OFS_STATUS) ?
                  req.wdata[`ST_WIDTH-1:0] : '0)) | events;
        irq_d  = |(stat_d & mask_d);
        // Read data for the next cycle
        rdata_d = 32'h0000_0000;
        if (req.rd) begin
            unique case (req.addr)
                `OFS_CTRL:     rdata_d = {24'h000000, ctrl_q};
                `OFS_PRESCALE: rdata_d = {16'h0000, psc_q};
                `OFS_RELOAD:   rdata_d = {16'h0000, reload_q};
                `OFS_REPEAT:   rdata_d = {16'h0000, rep_q, rep_cfg_q};
                `OFS_CHMODE:   rdata_d = {20'h00000, chmode_q};
                `OFS_DEADTIME: rdata_d = {24'h000000, dead_q};
                `OFS_BREAKCFG: rdata_d = {27'h0000000, brk_q, brk_cfg_q};
                `OFS_STATUS:   rdata_d = {25'h0000000, stat_q};
                `OFS_MASK:     rdata_d = {25'h0000000, mask_q};
                `OFS_COUNT:    rdata_d = {15'h0000, down_q, cnt_q};
                default: begin
                    for (int i = 0; i < 4; i++) begin
                        if (req.addr == `OFS_CCV0 + 8'(4*i)) begin
                            rdata_d = {16'h0000, ccv_q[i]};
                        end
                    end
                end
            endcase
        end
    end

    // Register all state
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            ctrl_q      <= 8'h00;
            psc_q       <= `RST_PRESCALE;
            pcnt_q      <= 16'h0000;
            reload_q    <= `RST_RELOAD;
            cnt_q       <= 16'h0000;
            down_q      <= 1'b0;
            rep_cfg_q   <= 8'h00;
            rep_q       <= 8'h00;
            chmode_q    <= 12'h000;
            dead_q      <= `RST_DEADTIME;
            brk_cfg_q   <= 4'h0;
            brk_q       <= 1'b0;
            stat_q      <= '0;
            mask_q      <= '0;
            ccv_q       <= '{default: 16'h0000};
            cap_prev_q  <= 4'h0;
            hall_prev_q <= hall_in;                            // No false edge after reset
            ch_out      <= 4'h0;
            rdata_out   <= 32'h0000_0000;
            irq_out     <= 1'b0;
        end else begin
            ctrl_q      <= ctrl_d;
            psc_q       <= psc_d;
            pcnt_q      <= pcnt_d;
            reload_q    <= reload_d;
            cnt_q       <= cnt_d;
            down_q      <= down_d;
            rep_cfg_q   <= rep_cfg_d;
            rep_q       <= rep_d;
            chmode_q    <= chmode_d;
            dead_q      <= dead_d;
            brk_cfg_q   <= brk_cfg_d;
            brk_q       <= brk_d;
            stat_q      <= stat_d;
            mask_q      <= mask_d;
            ccv_q       <= ccv_d;
            cap_prev_q  <= capture_in;
            hall_prev_q <= hall_in;
            ch_out      <= ch_d;
            rdata_out   <= rdata_d;
            irq_out     <= irq_d;
        end
    end

    // ****************************************
    // Three complementary phase pairs
    // ****************************************
    for (genvar p = 0; p < 3; p++) begin : g_phase
        pin_pair_s safe;
        pin_pair_s pair;
        // Safe level: all off in reset style, or the chosen levels
        assign safe.main = brk_cfg_q[1] & brk_cfg_q[2];
        assign safe.comp = brk_cfg_q[1] & brk_cfg_q[3];
        dead_time_pair u_pair (
            .clock_in (clock_in),
            .srst_in  (srst_in),
            .ref_in   (ch_out[p]),
            .dead_in  (dead_q),
            .force_in (brk_cfg_q[0] & (brk_q | break_in)),
            .safe_in  (safe),
            .pair_out (pair)
        );
        assign phase_hi_out[p] = pair.main;
        assign phase_lo_out[p] = pair.comp;
    end

    // ****************************************
    // Checks
    // ****************************************
    up_wrap_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (tick && mode == COUNT_UP && cnt_q == reload_q) |=> (cnt_q == 16'h0000))
        else $error("up count did not wrap");
    down_reload_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (tick && mode == COUNT_DOWN && cnt_q == 16'h0000) |=> (cnt_q == $past(reload_q)))
        else $error("down count did not reload");
    prescale_hold_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (!tick && !req.wr) |=> $stable(cnt_q))
        else $error("counter moved without tick");
    prescale_gap_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (tick && psc_q != 16'h0000 && !req.wr) |=> !tick)
        else $error("prescaler ticked twice in a row");
    center_turn_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (tick && mode == COUNT_CENTER && !down_q && cnt_q >= reload_q) |=> down_q)
        else $error("center count did not turn down");
    capture_latch_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (chmode_q[2:0] == 3'h1 && (cap_edge[0] || hall_edge) && !req.wr) |=>
        (ccv_q[0] == $past(cnt_q)))
        else $error("capture missed");
    compare_toggle_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (chmode_q[8:6] == 3'h2 && tick && cnt_q == ccv_q[2]) |=>
        (ch_out[2] != $past(ch_out[2])))
        else $error("compare did not toggle");
    pwm_level_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (chmode_q[2:0] == 3'h3) |=> (ch_out[0] == ($past(cnt_q) < $past(ccv_q[0]))))
        else $error("pwm level wrong");
    single_stop_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (ctrl_q[3] && events[0] && !req.wr) |=> !ctrl_q[0])
        else $error("single pulse kept running");
    break_force_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (break_in && brk_cfg_q[0] && !brk_cfg_q[1]) ##1 $stable(brk_cfg_q) |=>
        (phase_hi_out == 3'h0 && phase_lo_out == 3'h0))
        else $error("break did not force outputs");
    hall_flag_a: assert property (@(posedge clock_in) disable iff (srst_in)
        hall_edge |=> stat_q[`ST_HALL])
        else $error("hall edge not flagged");
    rep_count_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (period_end && rep_q != 8'h00) |=> (rep_q == $past(rep_q) - 8'h01))
        else $error("repetition count wrong");
    irq_level_a: assert property (@(posedge clock_in) disable iff (srst_in)
        ((|(stat_q & mask_q)) && !req.wr) |=> irq_out)
        else $error("pending event without interrupt");
    rdata_idle_a: assert property (@(posedge clock_in) disable iff (srst_in)
        !req.rd |=> (rdata_out == 32'h0000_0000))
        else $error("read data without a read");

    cover_update_c:  cover property (@(posedge clock_in) events[`ST_UPDATE]);
    cover_center_c:  cover property (@(posedge clock_in) mode == COUNT_CENTER && down_q);
    cover_break_c:   cover property (@(posedge clock_in) break_in && brk_cfg_q[0]);
    cover_capture_c: cover property (@(posedge clock_in) events[`ST_CH0]);
    cover_toggle_c:  cover property (@(posedge clock_in) chmode_q[8:6] == 3'h2 && events[3]);

endmodule

// File: testbench/gate_drive_model.sv
// Half-bridge gate stage and hall sensors on the far side of the timer
module gate_drive_model
    import motor_timer_pkg::*;
(
    // Clock and rotor step request
    input  wire logic       clock_in,
    input  wire logic       step_in,
    // Gate inputs of the power stage
    input  wire logic [2:0] phase_hi_in,
    input  wire logic [2:0] phase_lo_in,
    // Sensor lines and fault report
    output logic [2:0]      hall_out,
    output logic            shoot_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] pos_q = 3'h0;
    logic       shoot_q = 1'b0;
    logic [2:0] code [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
    assign shoot_out = shoot_q;
    // Rotor advances one sector per step, one hall line changes each time
    always @(posedge clock_in) begin
        if (step_in) pos_q <= (pos_q == 3'h5) ? 3'h0 : pos_q + 3'h1;
    end
    assign hall_out = code[pos_q];
    // Both switches of one leg on would short the supply, so it is latched
    always @(posedge clock_in) begin
        if (|(phase_hi_in & phase_lo_in)) shoot_q <= 1'b1;
    end
endmodule

// File: testbench/motor_timer_tb_top.sv
`include "motor_timer_defines.svh"

module motor_timer_tb_top
    import motor_timer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_in = 1'b0;
    logic        srst_in = 1'b1;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        brk = 1'b0;
    logic        step = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [31:0] d;
    logic [31:0] e;
    logic [3:0]  cap = 4'h0;
    logic [3:0]  ch;
    logic [2:0]  hall;
    logic [2:0]  hi;
    logic [2:0]  lo;
    logic        irq;
    logic        shoot;
    logic [15:0] q [12];
    logic [15:0] cv [4] = '{16'h4, 16'h2, 16'h1, 16'h2};
    int          n [6];
    int          want [6] = '{24, 12, 24, 36, 18, 18};
    int          num_errors = 0;
    int          total_checks = 0;

    // ****************************************
    // Clock, design and far side
    // ****************************************
    always #5 clock_in = ~clock_in;

    motor_timer motor_timer_i (.clock_in(clock_in), .srst_in(srst_in), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .capture_in(cap),
        .hall_in(hall), .break_in(brk), .ch_out(ch), .phase_hi_out(hi),
        .phase_lo_out(lo), .irq_out(irq));

    gate_drive_model gate_drive_model_i (.clock_in(clock_in), .step_in(step),
        .phase_hi_in(hi), .phase_lo_in(lo), .hall_out(hall), .shoot_out(shoot));

    // ****************************************
    // Bus cycles and comparison
    // ****************************************
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock_in);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clock_in);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] exp);
        @(posedge clock_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock_in);
        rd <= 1'b0;
        #1 d = rdata;
        chk(name, exp, d & m);
    endtask

    // Back-to-back reads of the counter, one sample per cycle
    task automatic run(input logic [31:0] ctl, input logic [31:0] rel, input logic [31:0] pre);
        wr_reg(`OFS_RELOAD, rel);
        wr_reg(`OFS_PRESCALE, pre);
        wr_reg(`OFS_CTRL, ctl);
        repeat (4) @(posedge clock_in);
        addr <= `OFS_COUNT;
        rd <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            @(posedge clock_in);
            #1 q[i] = rdata[15:0];
        end
        rd <= 1'b0;
    endtask

    task automatic pulse(input int b);
        @(posedge clock_in);
        cap[b] <= 1'b1;
        @(posedge clock_in);
        cap[b] <= 1'b0;
    endtask

    task automatic print_verdict();
        $display("Checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog well beyond the few hundred cycles of the sequence
    initial begin
        #500000;
        num_errors++;
        print_verdict();
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge clock_in);
        srst_in <= 1'b0;
        rd_chk("reload", `OFS_RELOAD, 32'hFFFF, 32'hFFFF);
        rd_chk("prescale", `OFS_PRESCALE, 32'hFFFF, 32'h0);
        wr_reg(8'h40, 32'h5);
        rd_chk("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
        chk("pins", 32'hE, 32'({ch, hi, lo, irq})); // low sides on while idle
        // Up count wraps to zero after the reload value
        run(32'h1, 32'h3, 32'h0);
        for (int i = 1; i < 12; i++) chk("up", (q[i-1] == 16'h3) ? 16'h0 : q[i-1] + 16'h1, q[i]);
        rd_chk("update", `OFS_STATUS, 32'h1, 32'h1);
        run(32'h3, 32'h3, 32'h0);
        for (int i = 1; i < 12; i++) chk("down", (q[i-1] == 16'h0) ? 16'h3 : q[i-1] - 16'h1, q[i]);
        // Center mode goes both ways and stays inside the period
        run(32'h5, 32'h3, 32'h0);
        e = 32'h0;
        for (int i = 1; i < 12; i++) begin
            if (q[i] + 16'h1 == q[i-1]) e[0] = 1'b1;
            if (q[i] == q[i-1] + 16'h1) e[1] = 1'b1;
            if (q[i] > 16'h3) e[2] = 1'b1;
        end
        chk("center", 32'h3, e);
        // Single pulse: counter stands still after one period
        run(32'h9, 32'h3, 32'h0);
        e = 32'h0;
        for (int i = 6; i < 12; i++) if (q[i] != q[11] || q[i] > 16'h3) e[0] = 1'b1;
        chk("one pulse", 32'h0, e);
        // Compare outputs over three toggle periods of 16 cycles
        wr_reg(`OFS_CHMODE, 32'({CH_PWM_INV, CH_TOGGLE, CH_PWM, CH_PWM}));
        foreach (cv[k]) wr_reg(`OFS_CCV0 + 8'(4 * k), 32'(cv[k]));
        wr_reg(`OFS_DEADTIME, 32'h1);
        rd_chk("value", `OFS_CCV0 + 8'h4, 32'hFFFF, 32'h2);
        run(32'h1, 32'h7, 32'h0);
        n = '{default: 0};
        repeat (48) begin
            @(posedge clock_in);
            #1;
            for (int k = 0; k < 4; k++) n[k] += int'(ch[k]);
            n[4] += int'(hi[0]);
            n[5] += int'(lo[0]);
        end
        for (int k = 0; k < 6; k++) chk("high cycles", want[k], n[k]);
        chk("overlap", 32'h0, 32'(shoot));
        // Break forces the safe pattern, then all off
        wr_reg(`OFS_MASK, 32'h0);
        wr_reg(`OFS_BREAKCFG, 32'h7);
        @(posedge clock_in);
        brk <= 1'b1;
        repeat (3) @(posedge clock_in);
        #1 chk("safe", 32'h38, 32'({hi, lo}));
        chk("irq masked", 32'h0, 32'(irq));
        wr_reg(`OFS_MASK, 32'h20);
        repeat (2) @(posedge clock_in);
        #1 chk("irq", 32'h1, 32'(irq));
        wr_reg(`OFS_BREAKCFG, 32'h1);
        repeat (3) @(posedge clock_in);
        #1 chk("all off", 32'h0, 32'({hi, lo}));
        rd_chk("latched", `OFS_BREAKCFG, 32'h10, 32'h10);
        brk <= 1'b0;
        wr_reg(`OFS_STATUS, 32'h20);
        rd_chk("break clear", `OFS_STATUS, 32'h20, 32'h0);
        #1 chk("irq clear", 32'h0, 32'(irq));
        // Divide by three: count steps once every three cycles
        run(32'h1, 32'hFFFF, 32'h2);
        for (int i = 3; i < 12; i++) chk("divide", q[i-3] + 16'h1, q[i]);
        // Two captures 21 cycles apart measure the width
        wr_reg(`OFS_PRESCALE, 32'h0);
        wr_reg(`OFS_CHMODE, 32'({CH_CAPTURE, CH_CAPTURE, CH_OFF, CH_CAPTURE}));
        // Sample the count, the first capture lands two counts later
        @(posedge clock_in);
        addr <= `OFS_COUNT;
        rd <= 1'b1;
        @(posedge clock_in);
        rd <= 1'b0;
        #1 e = (rdata & 32'hFFFF) + 32'd2;
        pulse(2);
        repeat (19) @(posedge clock_in);
        pulse(3);
        rd_chk("ch2", `OFS_CCV0 + 8'h8, 32'hFFFF, e);
        e = d + 32'd21;
        rd_chk("width", `OFS_CCV0 + 8'hC, 32'hFFFF, e);
        rd_chk("ch flags", `OFS_STATUS, 32'h18, 32'h18);
        // Hall change raises its event
        wr_reg(`OFS_STATUS, 32'h40);
        @(posedge clock_in);
        step <= 1'b1;
        @(posedge clock_in);
        step <= 1'b0;
        repeat (3) @(posedge clock_in);
        rd_chk("hall", `OFS_STATUS, 32'h40, 32'h40);
        wr_reg(`OFS_REPEAT, 32'h2);
        rd_chk("repeat", `OFS_REPEAT, 32'hFF, 32'h2);
        // Short period: the update event comes on every third wrap only
        wr_reg(`OFS_RELOAD, 32'h3);
        wr_reg(`OFS_STATUS, 32'h1);
        repeat (2) @(posedge clock_in);
        rd_chk("no update", `OFS_STATUS, 32'h1, 32'h0);
        repeat (6) @(posedge clock_in);
        rd_chk("third update", `OFS_STATUS, 32'h1, 32'h1);
        print_verdict();
    end
endmodule
